// ---- hw/sfci_regs.svh ----
// Opcodes, field positions and timing counts of the serial flash host controller
`ifndef SFCI_REGS_SVH
`define SFCI_REGS_SVH
`define SFCI_OP_CONT_READ 8'he8
`define SFCI_OP_PAGE_READ 8'hd2
`define SFCI_OP_STATUS_READ 8'hd7
`define SFCI_OP_BUF1_READ 8'hd4
`define SFCI_OP_BUF2_READ 8'hd6
`define SFCI_OP_BUF1_WRITE 8'h84
`define SFCI_OP_BUF2_WRITE 8'h87
`define SFCI_OP_PROG_ERASE_B1 8'h83
`define SFCI_OP_PROG_ERASE_B2 8'h86
`define SFCI_OP_PROG_NOERASE_B1 8'h88
`define SFCI_OP_PROG_NOERASE_B2 8'h89
`define SFCI_OP_PROG_THRU_B1 8'h82
`define SFCI_OP_PROG_THRU_B2 8'h85
`define SFCI_OP_XFER_B1 8'h53
`define SFCI_OP_XFER_B2 8'h55
`define SFCI_OP_COMP_B1 8'h60
`define SFCI_OP_COMP_B2 8'h61
`define SFCI_OP_REWRITE_B1 8'h58
`define SFCI_OP_REWRITE_B2 8'h59
`define SFCI_OP_PAGE_ERASE 8'h81
`define SFCI_OP_BLOCK_ERASE 8'h50
`define SFCI_STAT_COMPARE_BIT 6
`define SFCI_STAT_READY_BIT 7
`define SFCI_PROTECTED_PAGES 256
`define SFCI_SCK_DIV 8
`define SFCI_CS_GAP 4
`endif

// ---- hw/sfci_pkg.sv ----
// Types shared by the serial flash host controller
package sfci_pkg;
  typedef enum logic [1:0] {
    SFCI_CLS_BUFFER,
    SFCI_CLS_STATUS,
    SFCI_CLS_ARRAY
  } sfci_class_e;
  typedef logic [7:0] sfci_byte_t;
endpackage : sfci_pkg

// ---- hw/sfci_sync.sv ----
// Two-flop synchroniser for levels entering the system clock domain
`timescale 1ns/1ps
`default_nettype none
module sfci_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] reset_val_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  // First flop is only read by the second
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in ^ reset_val_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q ^ reset_val_in;
endmodule : sfci_sync
`default_nettype wire

// ---- hw/sfci_shifter.sv ----
// Byte shifter for the serial link: mode 0 timing from a divided clock
`timescale 1ns/1ps
`default_nettype none
`include "sfci_regs.svh"
module sfci_shifter (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic start_in,
  input wire logic [7:0] tx_byte_in,
  input wire logic miso_in,
  output logic busy_out,
  output logic done_out,
  output logic [7:0] rx_byte_out,
  output logic sck_out,
  output logic mosi_out
);
  logic [3:0] div_q;
  logic [3:0] bit_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic active_q;
  logic done_q;
  logic sck_q;
  logic half;
  assign half = (div_q == 4'(`SFCI_SCK_DIV / 2 - 1));
  // Divider makes the serial clock; the link has no second domain at this end
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      div_q <= 4'h0;
      sck_q <= 1'b0;
      bit_q <= 4'h0;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      active_q <= 1'b0;
      done_q <= 1'b0;
    end else if (clk_en_in) begin
      done_q <= 1'b0;
      if (!active_q) begin
        if (start_in) begin
          active_q <= 1'b1;
          tx_q <= tx_byte_in;
          bit_q <= 4'h0;
          div_q <= 4'h0;
        end
      end else if (half) begin
        div_q <= 4'h0;
        sck_q <= !sck_q;
        if (!sck_q) begin
          rx_q <= {rx_q[6:0], miso_in};
        end else begin
          tx_q <= {tx_q[6:0], 1'b0};
          bit_q <= bit_q + 4'h1;
          if (bit_q == 4'h7) begin
            active_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
      end else begin
        div_q <= div_q + 4'h1;
      end
    end
  end
  assign busy_out = active_q;
  assign done_out = done_q;
  assign rx_byte_out = rx_q;
  assign sck_out = sck_q;
  assign mosi_out = tx_q[7];
endmodule : sfci_shifter
`default_nettype wire

// ---- hw/sfci_host.sv ----
// Host controller that drives the serial page flash through its pins
// Contract
// - Host never starts an array command while another array command runs.
// - Data presented for rising-edge capture, read back after falling-edge shift.
// - Each command framed by select falling edge and select rising edge.
// - Each read has legacy and mode 0/3 opcodes; host uses mode 0/3 set.
// - 83H/86H program page from buffer 1/2 with erase.
// - 88H/89H program erased page from buffer 1/2 without erase.
// - 82H/85H write buffer 1/2 then program page.
// - 53H/55H transfer page into buffer 1/2.
// - 60H/61H compare page with buffer 1/2.
// - 58H/59H auto page rewrite through buffer 1/2.
// - 81H erases a single page.
// - 50H erases a block of eight pages.
`timescale 1ns/1ps
`default_nettype none
`include "sfci_regs.svh"
module sfci_host
  import sfci_pkg::*;
#(
  parameter int RESET_HOLD = 16
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire logic [7:0] cmd_opcode_in,
  input wire logic [23:0] cmd_addr_in,
  input wire logic [15:0] cmd_len_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [7:0] wr_data_in,
  output logic rd_valid_out,
  output logic [7:0] rd_data_out,
  output logic cmd_done_out,
  output logic cmd_refused_out,
  output logic compare_mismatch_out,
  input wire logic protect_en_in,
  input wire logic dev_reset_req_in,
  output logic flash_cs_n_out,
  output logic flash_sck_out,
  output logic flash_si_out,
  input wire logic flash_so_in,
  output logic flash_wp_n_out,
  output logic flash_reset_n_out,
  input wire logic flash_ready_in
);
  import sfci_pkg::*;

  typedef enum logic [2:0] {
    SFCI_IDLE,
    SFCI_SEL,
    SFCI_SHIFT,
    SFCI_DESEL,
    SFCI_POLL,
    SFCI_RESET
  } sfci_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode classes
  function automatic sfci_class_e op_class(input logic [7:0] op);
    case (op)
      `SFCI_OP_BUF1_READ, `SFCI_OP_BUF2_READ,
      `SFCI_OP_BUF1_WRITE, `SFCI_OP_BUF2_WRITE: op_class = SFCI_CLS_BUFFER;
      `SFCI_OP_STATUS_READ: op_class = SFCI_CLS_STATUS;
      default: op_class = SFCI_CLS_ARRAY;
    endcase
  endfunction : op_class

  // Commands that change array contents and fall under write protect
  function automatic logic is_modify(input logic [7:0] op);
    case (op)
      `SFCI_OP_PROG_ERASE_B1, `SFCI_OP_PROG_ERASE_B2,
      `SFCI_OP_PROG_NOERASE_B1, `SFCI_OP_PROG_NOERASE_B2,
      `SFCI_OP_PROG_THRU_B1, `SFCI_OP_PROG_THRU_B2,
      `SFCI_OP_REWRITE_B1, `SFCI_OP_REWRITE_B2,
      `SFCI_OP_PAGE_ERASE, `SFCI_OP_BLOCK_ERASE: is_modify = 1'b1;
      default: is_modify = 1'b0;
    endcase
  endfunction : is_modify

  // Buffer touched by a command: 1 or 2, 0 for none
  function automatic logic [1:0] buf_of(input logic [7:0] op);
    case (op)
      `SFCI_OP_BUF1_READ, `SFCI_OP_BUF1_WRITE, `SFCI_OP_PROG_ERASE_B1,
      `SFCI_OP_PROG_NOERASE_B1, `SFCI_OP_PROG_THRU_B1, `SFCI_OP_XFER_B1,
      `SFCI_OP_COMP_B1, `SFCI_OP_REWRITE_B1: buf_of = 2'h1;
      `SFCI_OP_BUF2_READ, `SFCI_OP_BUF2_WRITE, `SFCI_OP_PROG_ERASE_B2,
      `SFCI_OP_PROG_NOERASE_B2, `SFCI_OP_PROG_THRU_B2, `SFCI_OP_XFER_B2,
      `SFCI_OP_COMP_B2, `SFCI_OP_REWRITE_B2: buf_of = 2'h2;
      default: buf_of = 2'h0;
    endcase
  endfunction : buf_of

  function automatic logic is_known(input logic [7:0] op);
    case (op)
      `SFCI_OP_CONT_READ, `SFCI_OP_PAGE_READ, `SFCI_OP_STATUS_READ,
      `SFCI_OP_BUF1_READ, `SFCI_OP_BUF2_READ, `SFCI_OP_BUF1_WRITE,
      `SFCI_OP_BUF2_WRITE, `SFCI_OP_XFER_B1, `SFCI_OP_XFER_B2,
      `SFCI_OP_COMP_B1, `SFCI_OP_COMP_B2, `SFCI_OP_PAGE_ERASE,
      `SFCI_OP_BLOCK_ERASE: is_known = 1'b1;
      default: is_known = is_modify(op);
    endcase
  endfunction : is_known

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs pass two flops; ready idles high, so it resets high
  logic [1:0] pins_sync;
  logic so_s;
  logic ready_s;
  sfci_sync #(.WIDTH(2)) u_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .async_in({flash_so_in, flash_ready_in}),
    .reset_val_in(2'b01),
    .sync_out(pins_sync)
  );
  assign so_s = pins_sync[1];
  assign ready_s = pins_sync[0];

  ////////////////////////////////////////////////////////////////////////////
  // Byte shifter
  logic sh_start;
  logic sh_busy;
  logic sh_done;
  logic [7:0] sh_tx;
  logic [7:0] sh_rx;
  logic sh_sck;
  sfci_shifter u_shift (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .start_in(sh_start),
    .tx_byte_in(sh_tx),
    .miso_in(so_s),
    .busy_out(sh_busy),
    .done_out(sh_done),
    .rx_byte_out(sh_rx),
    .sck_out(sh_sck),
    .mosi_out(flash_si_out)
  );
  // SCK idles low at select fall, so the device picks mode 0
  assign flash_sck_out = sh_sck;

  ////////////////////////////////////////////////////////////////////////////
  sfci_state_e state_q;
  logic [7:0] op_q;
  logic [23:0] addr_q;
  logic [15:0] len_q;
  logic [15:0] cnt_q;
  logic [3:0] gap_q;
  logic [7:0] rst_q;
  logic cs_n_q;
  logic array_busy_q;
  logic [1:0] busy_buf_q;
  logic poll_q;
  logic rd_valid_q;
  logic [7:0] rd_data_q;
  logic done_q;
  logic refused_q;
  logic mismatch_q;
  logic [15:0] total;
  logic [15:0] status_len;
  sfci_class_e cls_in;
  logic blocked;
  logic protected_hit;
  logic is_write;
  logic is_read;

  assign cls_in = op_class(cmd_opcode_in);
  // refuse the buffer held by a running array command
  assign blocked = array_busy_q &&
                   (cls_in == SFCI_CLS_ARRAY ||
                    (buf_of(cmd_opcode_in) != 2'h0 && buf_of(cmd_opcode_in) == busy_buf_q));
  // page field sits at address bits 19:9; low 256 pages protected
  assign protected_hit = protect_en_in && is_modify(cmd_opcode_in) &&
                         (cmd_addr_in[19:9] < 11'(`SFCI_PROTECTED_PAGES));
  assign is_write = (op_q == `SFCI_OP_BUF1_WRITE) || (op_q == `SFCI_OP_BUF2_WRITE) ||
                    (op_q == `SFCI_OP_PROG_THRU_B1) || (op_q == `SFCI_OP_PROG_THRU_B2);
  assign is_read = !is_write && (poll_q || op_class(op_q) != SFCI_CLS_ARRAY ||
                   op_q == `SFCI_OP_CONT_READ || op_q == `SFCI_OP_PAGE_READ);
  // Header length: opcode plus three address bytes, status read opcode only; array and buffer reads add dummy bytes
  assign total = poll_q ? 16'h0001 :
                 (op_q == `SFCI_OP_STATUS_READ) ? 16'h0001 :
                 (op_q == `SFCI_OP_CONT_READ || op_q == `SFCI_OP_PAGE_READ) ? 16'h0008 :
                 (op_q == `SFCI_OP_BUF1_READ || op_q == `SFCI_OP_BUF2_READ) ? 16'h0005 :
                 16'h0004;
  assign status_len = poll_q ? 16'h0002 : total + (is_read || is_write ? len_q : 16'h0000);

  // Commands taken in idle outside device reset; colliding ones are refused after
  assign cmd_ready_out = (state_q == SFCI_IDLE) && !dev_reset_req_in && (rst_q == 8'h00);
  assign wr_ready_out = (state_q == SFCI_SHIFT) && is_write && !sh_busy && !sh_done &&
                        (cnt_q >= total) && (cnt_q < status_len);

  // Shifter byte source
  always_comb begin
    sh_tx = 8'h00;
    if (cnt_q == 16'h0000) begin
      sh_tx = poll_q ? `SFCI_OP_STATUS_READ : op_q;
    end else if (cnt_q < 16'h0004 && !poll_q && op_q != `SFCI_OP_STATUS_READ) begin
      sh_tx = (cnt_q == 16'h0001) ? addr_q[23:16] :
              (cnt_q == 16'h0002) ? addr_q[15:8] : addr_q[7:0];
    end else if (is_write) begin
      sh_tx = wr_data_in;
    end
  end
  assign sh_start = (state_q == SFCI_SHIFT) && !sh_busy && !sh_done &&
                    (cnt_q < status_len) &&
                    (!(is_write && cnt_q >= total) || wr_valid_in);

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= SFCI_RESET;
      op_q <= 8'h00;
      addr_q <= 24'h000000;
      len_q <= 16'h0000;
      cnt_q <= 16'h0000;
      gap_q <= 4'h0;
      cs_n_q <= 1'b1;
      poll_q <= 1'b0;
      refused_q <= 1'b0;
    end else if (clk_en_in) begin
      refused_q <= 1'b0;
      case (state_q)
        SFCI_IDLE: begin
          if (dev_reset_req_in || rst_q != 8'h00) begin
            state_q <= SFCI_RESET;
          end else if (array_busy_q && !cmd_valid_in) begin
            poll_q <= 1'b1;
            state_q <= SFCI_SEL;
          end else if (cmd_valid_in) begin
            if (blocked || protected_hit || !is_known(cmd_opcode_in)) begin
              refused_q <= 1'b1;
            end else begin
              op_q <= cmd_opcode_in;
              addr_q <= cmd_addr_in;
              len_q <= cmd_len_in;
              poll_q <= 1'b0;
              state_q <= SFCI_SEL;
            end
          end
        end
        SFCI_SEL: begin
          cs_n_q <= 1'b0;
          cnt_q <= 16'h0000;
          state_q <= SFCI_SHIFT;
        end
        SFCI_SHIFT: begin
          if (sh_done) begin
            cnt_q <= cnt_q + 16'h0001;
          end
          if (!sh_busy && !sh_done && !sh_start && cnt_q >= status_len) begin
            state_q <= SFCI_DESEL;
          end
        end
        SFCI_DESEL: begin
          // select rising ends the frame and launches array work
          cs_n_q <= 1'b1;
          gap_q <= 4'(`SFCI_CS_GAP);
          state_q <= SFCI_POLL;
        end
        SFCI_POLL: begin
          if (gap_q != 4'h0) begin
            gap_q <= gap_q - 4'h1;
          end else begin
            poll_q <= 1'b0;
            state_q <= SFCI_IDLE;
          end
        end
        SFCI_RESET: begin
          // No frame until the device has left its own reset
          if (!dev_reset_req_in && rst_q == 8'h00) begin
            state_q <= SFCI_IDLE;
          end
        end
        default: state_q <= SFCI_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // device reset pulse, held RESET_HOLD cycles and while requested
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rst_q <= 8'(RESET_HOLD);
    end else if (clk_en_in) begin
      if (dev_reset_req_in) begin
        rst_q <= 8'(RESET_HOLD);
      end else if (rst_q != 8'h00) begin
        rst_q <= rst_q - 8'h01;
      end
    end
  end
  assign flash_reset_n_out = (rst_q == 8'h00) && !dev_reset_req_in;

  ////////////////////////////////////////////////////////////////////////////
  // Array busy tracking from status polls and the ready pin
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      array_busy_q <= 1'b0;
      busy_buf_q <= 2'h0;
      mismatch_q <= 1'b0;
      done_q <= 1'b0;
    end else if (clk_en_in) begin
      done_q <= 1'b0;
      if (state_q == SFCI_RESET || dev_reset_req_in) begin
        array_busy_q <= 1'b0;
        busy_buf_q <= 2'h0;
      end else if (state_q == SFCI_DESEL && !poll_q) begin
        done_q <= 1'b1;
        if (op_class(op_q) == SFCI_CLS_ARRAY && op_q != `SFCI_OP_CONT_READ &&
            op_q != `SFCI_OP_PAGE_READ) begin
          array_busy_q <= 1'b1;
          busy_buf_q <= buf_of(op_q);
        end
      end else if (poll_q && sh_done && cnt_q == 16'h0001 && sh_rx[`SFCI_STAT_READY_BIT] &&
                   ready_s) begin
        // only free once status and pin both show ready
        array_busy_q <= 1'b0;
        busy_buf_q <= 2'h0;
        // compare outcome from status bit 6
        mismatch_q <= sh_rx[`SFCI_STAT_COMPARE_BIT];
      end
    end
  end

  // Read data capture past the header bytes
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
    end else if (clk_en_in) begin
      rd_valid_q <= sh_done && !poll_q && is_read && (cnt_q >= total);
      if (sh_done) begin
        rd_data_q <= sh_rx;
      end
    end
  end

  // select held high outside frames and through reset
  assign flash_cs_n_out = cs_n_q;
  // protect pin driven high unless protection asked for
  assign flash_wp_n_out = !protect_en_in;
  assign rd_valid_out = rd_valid_q;
  assign rd_data_out = rd_data_q;
  assign cmd_done_out = done_q;
  assign cmd_refused_out = refused_q;
  assign compare_mismatch_out = mismatch_q;
endmodule : sfci_host
`default_nettype wire

// ---- hw/unused_placeholder_none.sv ----
// Empty: no further design content
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- sim/sfci_host_props.sv ----
// Concurrent checks on the host controller pins
`timescale 1ns/1ps
`default_nettype none
module sfci_host_props (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_ready_out,
  input wire logic cmd_refused_out,
  input wire logic protect_en_in,
  input wire logic dev_reset_req_in,
  input wire logic flash_cs_n_out,
  input wire logic flash_sck_out,
  input wire logic flash_si_out,
  input wire logic flash_wp_n_out,
  input wire logic flash_reset_n_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Clock must sit low at select fall so the device picks mode 0
  property p_mode0_start; $fell(flash_cs_n_out) |-> !flash_sck_out; endproperty
  a_mode0_start: assert property (p_mode0_start) else $error("clock high at select fall");
  property p_sck_idle; flash_cs_n_out |-> !flash_sck_out; endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("clock moves while deselected");
  property p_si_hold; flash_sck_out && $past(flash_sck_out) |-> $stable(flash_si_out); endproperty
  a_si_hold: assert property (p_si_hold) else $error("data changed while clock high");
  property p_wp_level; 1'b1 |-> flash_wp_n_out == !protect_en_in; endproperty
  a_wp_level: assert property (p_wp_level) else $error("protect pin wrong level");
  property p_reset_pin; dev_reset_req_in |-> !flash_reset_n_out && !cmd_ready_out; endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset pin not low on request");
  property p_reset_hold; $fell(dev_reset_req_in) |-> !flash_reset_n_out [*3]; endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset pin released early");
  property p_accept;
    clk_en_in && cmd_valid_in && cmd_ready_out |-> ##[1:2] (cmd_refused_out || !flash_cs_n_out);
  endproperty
  a_accept: assert property (p_accept) else $error("taken command got no frame");
  property p_refuse_quiet; cmd_refused_out |-> flash_cs_n_out; endproperty
  a_refuse_quiet: assert property (p_refuse_quiet) else $error("refused command framed");
  property p_ready_idle; cmd_ready_out |-> flash_cs_n_out; endproperty
  a_ready_idle: assert property (p_ready_idle) else $error("ready while a frame is open");
endmodule : sfci_host_props
bind sfci_host sfci_host_props u_props (.clk_in(clk_in), .reset_in(reset_in),
  .clk_en_in(clk_en_in), .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out),
  .cmd_refused_out(cmd_refused_out), .protect_en_in(protect_en_in),
  .dev_reset_req_in(dev_reset_req_in), .flash_cs_n_out(flash_cs_n_out),
  .flash_sck_out(flash_sck_out), .flash_si_out(flash_si_out),
  .flash_wp_n_out(flash_wp_n_out), .flash_reset_n_out(flash_reset_n_out));
`default_nettype wire

// ---- sim/sfci_flash_model.sv ----
// Behavioural model of the serial page flash on the far side of the link
`timescale 1ns/1ps
`default_nettype none
module sfci_flash_model #(
  parameter int BUSY_CYC = 400
) (
  input wire logic clk_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic si_in,
  input wire logic wp_n_in,
  input wire logic reset_n_in,
  input wire logic mismatch_in,
  output logic so_out,
  output logic ready_out
);
  localparam logic [7:0] DATA = 8'h3c;
  logic sck_q = 1'b0, cs_q = 1'b1, mode_q = 1'b1, cmp_q = 1'b0, so_q = 1'b0;
  logic [7:0] op_q = 8'h00, last_op = 8'h00;
  logic [31:0] sh_q = 32'h00000000;
  int bits_q = 0, busy_q = 0, viol = 0, buf_q = 0;
  logic [7:0] stat, nxt;
  assign stat = {busy_q == 0, cmp_q, 6'h00};
  assign nxt = {sh_q[6:0], si_in};
  assign so_out = so_q;
  // Open drain pin shows the pull-up unless busy
  assign ready_out = (busy_q == 0);
  function automatic int buf_of(input logic [7:0] op);
    case (op)
      8'h83, 8'h88, 8'h82, 8'h53, 8'h60, 8'h58, 8'hd4, 8'h84: return 1;
      8'h86, 8'h89, 8'h85, 8'h55, 8'h61, 8'h59, 8'hd6, 8'h87: return 2;
      default: return 0;
    endcase
  endfunction : buf_of
  function automatic logic is_array(input logic [7:0] op);
    return (buf_of(op) != 0 && !(op inside {8'hd4, 8'hd6, 8'h84, 8'h87}))
      || (op inside {8'h81, 8'h50, 8'hd2, 8'he8});
  endfunction : is_array
  ////////////////////////////////////////////////////////////////
  // Reset pin aborts work and restores mode 3
  always @(posedge clk_in) begin
    sck_q <= sck_in;
    cs_q <= cs_n_in;
    // Floating output: pattern changes every cycle
    if (cs_n_in) so_q <= ~so_q;
    if (!reset_n_in) begin
      busy_q <= 0;
      bits_q <= 0;
      mode_q <= 1'b1;
    end else begin
      if (busy_q > 0) busy_q <= busy_q - 1;
      // Compare result lands in bit 6 as it ends
      if (busy_q == 1 && last_op inside {8'h60, 8'h61}) cmp_q <= mismatch_in;
      // Mode taken from clock level at select fall
      if (!cs_n_in && cs_q) begin
        mode_q <= sck_in;
        bits_q <= 0;
      end
      if (!cs_n_in && sck_in && !sck_q) begin
        sh_q <= {sh_q[30:0], si_in};
        bits_q <= bits_q + 1;
        // Array or busy buffer touched while busy
        if (bits_q == 7 && busy_q > 0 && (is_array(nxt) || (buf_of(nxt) != 0
            && buf_of(nxt) == buf_q))) viol <= viol + 1;
        if (bits_q == 7) op_q <= nxt;
      end
      // Shift out on fall: status or buffer data
      if (!cs_n_in && !sck_in && sck_q && bits_q >= 8)
        so_q <= (op_q == 8'hd7) ? stat[7 - bits_q % 8] : DATA[7 - bits_q % 8];
      // Work starts at select rise; low pages locked; rewrite runs twice
      if (cs_n_in && !cs_q && bits_q >= 32 && is_array(op_q) && !(op_q inside {8'hd2, 8'he8})
          && !(!wp_n_in && sh_q[19:9] < 256 && !(op_q inside {8'h53, 8'h55, 8'h60, 8'h61})))
      begin
        busy_q <= (op_q inside {8'h58, 8'h59}) ? 2 * BUSY_CYC : BUSY_CYC;
        last_op <= op_q;
        buf_q <= buf_of(op_q);
      end
    end
  end
endmodule : sfci_flash_model
`default_nettype wire

// ---- sim/serial_flash_command_interface_test.sv ----
// Self-checking bench for the serial flash host controller
`timescale 1ns/1ps
`default_nettype none
module serial_flash_command_interface_test;
  import sfci_pkg::*;
  localparam int LIM = 20000;
  localparam logic [23:0] HI = 24'h030000; // Page 384, above the locked range
  logic clk_in = 0, reset_in = 1, cmd_valid_in = 0, protect_en_in = 0, dev_reset_req_in = 0;
  logic mism = 0;
  logic [7:0] cmd_opcode_in = 8'h00;
  logic [23:0] cmd_addr_in = 24'h000000;
  logic [15:0] cmd_len_in = 16'h0000;
  logic cmd_ready_out, wr_ready_out, rd_valid_out, cmd_done_out, cmd_refused_out, cmp_out;
  logic cs_n, sck, si, so, wp_n, rst_n, rdy;
  logic [7:0] rd_data_out;
  sfci_byte_t last_rd;
  int err_count = 0, compares = 0;
  always #4 clk_in = ~clk_in;
  sfci_host #(.RESET_HOLD(4)) u_dut (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(1'b1),
    .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .cmd_opcode_in(cmd_opcode_in),
    .cmd_addr_in(cmd_addr_in), .cmd_len_in(cmd_len_in), .wr_valid_in(1'b1),
    .wr_ready_out(wr_ready_out), .wr_data_in(8'h5a), .rd_valid_out(rd_valid_out),
    .rd_data_out(rd_data_out), .cmd_done_out(cmd_done_out), .cmd_refused_out(cmd_refused_out),
    .compare_mismatch_out(cmp_out), .protect_en_in(protect_en_in),
    .dev_reset_req_in(dev_reset_req_in), .flash_cs_n_out(cs_n), .flash_sck_out(sck),
    .flash_si_out(si), .flash_so_in(so), .flash_wp_n_out(wp_n), .flash_reset_n_out(rst_n),
    .flash_ready_in(rdy));
  // Busy long enough to cover the buffer traffic run beside it
  sfci_flash_model #(.BUSY_CYC(1500)) u_flash (.clk_in(clk_in), .cs_n_in(cs_n), .sck_in(sck),
    .si_in(si), .wp_n_in(wp_n), .reset_n_in(rst_n), .mismatch_in(mism), .so_out(so),
    .ready_out(rdy));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  // Hand over one command and wait for its frame to end or its refusal
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [15:0] n_b,
                     input logic refd);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    @(posedge clk_in);
    #1;
    cmd_opcode_in = op;
    cmd_addr_in = a;
    cmd_len_in = n_b;
    cmd_valid_in = 1'b1;
    do begin
      @(negedge clk_in);
      n++;
      if (n > LIM) begin chk("ready wait", 1, 0); test_done(); end
    end while (cmd_ready_out !== 1'b1);
    @(posedge clk_in);
    #1;
    cmd_valid_in = 1'b0;
    do begin
      @(negedge clk_in);
      n++;
      if (rd_valid_out === 1'b1) last_rd = rd_data_out;
      if (cmd_refused_out === 1'b1) got = 1'b1;
      if (n > LIM) begin chk("frame wait", 1, 0); test_done(); end
    end while (cmd_done_out !== 1'b1 && cmd_refused_out !== 1'b1);
    @(negedge clk_in);
    chk("refused", refd, got);
  endtask : cmd
  // Let the array work finish and the controller see it on its next poll
  task automatic settle();
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < LIM) begin @(negedge clk_in); n++; end
    chk("device idle", 1, rdy);
    repeat (1000) @(negedge clk_in);
  endtask : settle
  task automatic t_opcodes();
    logic [7:0] ops[14] = '{8'h83, 8'h86, 8'h88, 8'h89, 8'h82, 8'h85, 8'h81, 8'h50,
                            8'h53, 8'h55, 8'h60, 8'h61, 8'h58, 8'h59};
    foreach (ops[i]) begin
      cmd(ops[i], HI, 16'h0000, 1'b0);
      chk("opcode", ops[i], u_flash.last_op);
      chk("busy pin", 0, rdy);
      chk("mode", 0, u_flash.mode_q);
      settle();
    end
    $display("test opcodes done");
  endtask : t_opcodes
  task automatic t_protect();
    @(posedge clk_in) #1 protect_en_in = 1'b1;
    cmd(8'h83, 24'h000a00, 16'h0000, 1'b1);
    chk("protect pin", 0, wp_n);
    cmd(8'h81, HI, 16'h0000, 1'b0);
    settle();
    @(posedge clk_in) #1 protect_en_in = 1'b0;
    cmd(8'h83, 24'h000a00, 16'h0000, 1'b0);
    chk("low page programmed", 8'h83, u_flash.last_op);
    settle();
    $display("test protect done");
  endtask : t_protect
  task automatic t_background();
    cmd(8'h83, HI, 16'h0000, 1'b0);
    cmd(8'hd6, 24'h000000, 16'h0002, 1'b0);
    chk("other buffer data", 8'h3c, last_rd);
    cmd(8'h84, 24'h000000, 16'h0001, 1'b1);
    cmd(8'h81, HI, 16'h0000, 1'b1);
    cmd(8'hd7, 24'h000000, 16'h0001, 1'b0);
    chk("status busy bit", 0, last_rd[7]);
    chk("overlap seen by device", 0, u_flash.viol);
    settle();
    $display("test background done");
  endtask : t_background
  task automatic t_rewrite();
    cmd(8'h58, HI, 16'h0000, 1'b0);
    repeat (600) @(negedge clk_in);
    cmd(8'h81, HI, 16'h0000, 1'b1);
    settle();
    cmd(8'h81, HI, 16'h0000, 1'b0);
    settle();
    $display("test rewrite done");
  endtask : t_rewrite
  task automatic t_compare();
    mism = 1'b1;
    cmd(8'h60, HI, 16'h0000, 1'b0);
    settle();
    chk("compare flag set", 1, cmp_out);
    mism = 1'b0;
    cmd(8'h61, HI, 16'h0000, 1'b0);
    settle();
    chk("compare flag clear", 0, cmp_out);
    $display("test compare done");
  endtask : t_compare
  task automatic t_devreset();
    cmd(8'h81, HI, 16'h0000, 1'b0);
    @(posedge clk_in);
    #1;
    dev_reset_req_in = 1'b1;
    repeat (3) @(negedge clk_in);
    chk("reset pin", 0, rst_n);
    chk("device aborted", 1, rdy);
    chk("not ready", 0, cmd_ready_out);
    @(posedge clk_in);
    #1;
    dev_reset_req_in = 1'b0;
    cmd(8'h81, HI, 16'h0000, 1'b0);
    chk("resumed", 0, rdy);
    settle();
    $display("test devreset done");
  endtask : t_devreset
  initial begin
    repeat (8) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    chk("power-up mode", 1, u_flash.mode_q);
    t_opcodes();
    t_protect();
    t_background();
    t_rewrite();
    t_compare();
    t_devreset();
    test_done();
  end
endmodule : serial_flash_command_interface_test
`default_nettype wire
